// *** core/ulc_pkg.sv ***
// constants for the usb link power and timeout configuration block
package ulc_pkg;
  // register map (byte address, word aligned)
  localparam logic [7:0] ADDR_LINK_CONFIG_ONE = 8'h84;
  localparam logic [7:0] ADDR_LINK_STATUS = 8'h8C;
  // field positions in usb_link_config_one
  localparam int BIT_SELF_ENTRY = 10;
  localparam int BIT_HOST_ACCEPT = 9;
  localparam int BIT_LTM_ON = 8;
  localparam int FS_TRIM_LO = 4;
  localparam int HS_TRIM_LO = 13;
  // values after reset when no eeprom or otp image is present
  localparam logic DEF_SELF_ENTRY = 1'h0;
  localparam logic DEF_HOST_ACCEPT = 1'h1;
  localparam logic DEF_LTM_ON = 1'h0;
  localparam logic [2:0] DEF_FS_TRIM = 3'h0;
  localparam logic [2:0] DEF_HS_TRIM = 3'h0;
  // timing of the inter-packet timeouts, in bit times (_BT) and tenths of a bit time
  localparam int FS_BASE_MIN_BT = 16;
  localparam int FS_BASE_MAX_BT = 18;
  localparam int TENTHS_PER_BT = 10;
  localparam int FS_TRIM_TENTHS_60MHZ = 2;
  localparam int HS_TRIM_BT_60MHZ = 8;
endpackage

// *** core/ulc_link_config.sv ***
// link power enables and inter-packet timeout trim register
// Notes on behaviour
// - self u1 entry needs enable and host feature
// - self entry and host accept act independently
// - host u1 requests accepted when enable set
// - latency tolerance messaging follows its enable
// - protected bits survive soft resets while protection on; i_rst still loads their hard defaults
// - fs trim counts phy clocks, scaled, added
// - base fs timeout is 16 to 18 bits
// - each phy clock adds 0.2 bit times
// - only the 60 mhz factor is built
// - outside full speed the hs trim is presented
// - self entry and ltm default image or 0
// - host accept default image or 1
// - fs trim default image or zero
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
module ulc_link_config #(
  parameter int FS_BASE_TENTHS = 170
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // default image from eeprom or otp, with presence flag
  input wire logic i_image_valid,
  input wire logic i_image_self_entry,
  input wire logic i_image_host_accept,
  input wire logic i_image_ltm_on,
  input wire logic [2:0] i_image_fs_trim,
  input wire logic [2:0] i_image_hs_trim,
  // soft resets and protection, same clock domain
  input wire logic i_usb_reset,
  input wire logic i_lite_reset,
  input wire logic i_reset_protect,
  // link state
  input wire logic i_host_u1_feature,
  input wire logic i_full_speed,
  // to the device controller
  output logic o_u1_self_entry_ok,
  output logic o_host_u1_accept,
  output logic o_ltm_active,
  output logic [2:0] o_timeout_trim,
  output logic [7:0] o_fs_timeout_tenths
);
  // configuration fields held for the controller
  logic dev_u1_self_entry_allow;
  logic host_u1_request_accept;
  logic latency_tolerance_msg_on;
  logic [2:0] fullspeed_timeout_trim;
  logic [2:0] highspeed_timeout_trim;

  // next values of the configuration fields
  logic next_self_entry;
  logic next_host_accept;
  logic next_ltm_on;
  logic [2:0] next_fs_trim;
  logic [2:0] next_hs_trim;

  // next values of the controller-facing outputs
  logic next_u1_self_entry_ok;
  logic next_host_u1_accept;
  logic next_ltm_active;
  logic [2:0] next_timeout_trim;
  logic [7:0] next_fs_timeout_tenths;

  // full-speed timeout arithmetic, tenths of a bit time
  logic [7:0] base_tenths;
  logic [7:0] trim_tenths;

  // soft reset, protection and register decode
  logic soft_rst;
  logic protected_reload;
  logic wr_cfg;
  logic rd_cfg;
  logic rd_status;

  // read path
  logic [31:0] cfg_word;
  logic [31:0] status_word;
  logic [31:0] next_rdata;

  // strobe aimed at one register of the map
  function automatic logic hits(input logic strobe, input logic [7:0] addr,
                                input logic [7:0] target);
    hits = strobe && (addr == target);
  endfunction

  // image bit when an image was loaded, hard default otherwise
  function automatic logic pick_bit(input logic valid, input logic image,
                                    input logic dflt);
    pick_bit = valid ? image : dflt;
  endfunction

  // image trim when an image was loaded, hard default otherwise
  function automatic logic [2:0] pick_trim(input logic valid, input logic [2:0] image,
                                           input logic [2:0] dflt);
    pick_trim = valid ? image : dflt;
  endfunction

  // either soft reset reloads; protection shields only bits 10:8
  assign soft_rst = i_usb_reset | i_lite_reset;
  assign protected_reload = soft_rst && !i_reset_protect;
  assign wr_cfg = hits(i_wr, i_addr, ulc_pkg::ADDR_LINK_CONFIG_ONE);
  assign rd_cfg = hits(i_rd, i_addr, ulc_pkg::ADDR_LINK_CONFIG_ONE);
  assign rd_status = hits(i_rd, i_addr, ulc_pkg::ADDR_LINK_STATUS);

  // self entry: reload beats a same-cycle write
  always_comb begin
    next_self_entry = dev_u1_self_entry_allow;
    if (protected_reload) begin
      next_self_entry = pick_bit(i_image_valid, i_image_self_entry,
                                 ulc_pkg::DEF_SELF_ENTRY);
    end else if (wr_cfg) begin
      next_self_entry = i_wdata[ulc_pkg::BIT_SELF_ENTRY];
    end
  end

  // self entry field
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dev_u1_self_entry_allow <= ulc_pkg::DEF_SELF_ENTRY;
    end else begin
      dev_u1_self_entry_allow <= next_self_entry;
    end
  end

  // host accept: reload beats a same-cycle write
  always_comb begin
    next_host_accept = host_u1_request_accept;
    if (protected_reload) begin
      next_host_accept = pick_bit(i_image_valid, i_image_host_accept,
                                  ulc_pkg::DEF_HOST_ACCEPT);
    end else if (wr_cfg) begin
      next_host_accept = i_wdata[ulc_pkg::BIT_HOST_ACCEPT];
    end
  end

  // host accept field
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      host_u1_request_accept <= ulc_pkg::DEF_HOST_ACCEPT;
    end else begin
      host_u1_request_accept <= next_host_accept;
    end
  end

  // latency tolerance enable: reload beats a same-cycle write
  always_comb begin
    next_ltm_on = latency_tolerance_msg_on;
    if (protected_reload) begin
      next_ltm_on = pick_bit(i_image_valid, i_image_ltm_on,
                             ulc_pkg::DEF_LTM_ON);
    end else if (wr_cfg) begin
      next_ltm_on = i_wdata[ulc_pkg::BIT_LTM_ON];
    end
  end

  // latency tolerance enable field
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      latency_tolerance_msg_on <= ulc_pkg::DEF_LTM_ON;
    end else begin
      latency_tolerance_msg_on <= next_ltm_on;
    end
  end

  // full-speed trim: every soft reset reloads it, protected or not
  always_comb begin
    next_fs_trim = fullspeed_timeout_trim;
    if (soft_rst) begin
      next_fs_trim = pick_trim(i_image_valid, i_image_fs_trim,
                               ulc_pkg::DEF_FS_TRIM);
    end else if (wr_cfg) begin
      next_fs_trim = i_wdata[ulc_pkg::FS_TRIM_LO +: 3];
    end
  end

  // full-speed trim field
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fullspeed_timeout_trim <= ulc_pkg::DEF_FS_TRIM;
    end else begin
      fullspeed_timeout_trim <= next_fs_trim;
    end
  end

  // high-speed trim: every soft reset reloads it, protected or not
  always_comb begin
    next_hs_trim = highspeed_timeout_trim;
    if (soft_rst) begin
      next_hs_trim = pick_trim(i_image_valid, i_image_hs_trim,
                               ulc_pkg::DEF_HS_TRIM);
    end else if (wr_cfg) begin
      next_hs_trim = i_wdata[ulc_pkg::HS_TRIM_LO +: 3];
    end
  end

  // high-speed trim field
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      highspeed_timeout_trim <= ulc_pkg::DEF_HS_TRIM;
    end else begin
      highspeed_timeout_trim <= next_hs_trim;
    end
  end

  // register image, reserved bits zero
  always_comb begin
    cfg_word = 32'h0;
    cfg_word[ulc_pkg::HS_TRIM_LO +: 3] = highspeed_timeout_trim;
    cfg_word[ulc_pkg::BIT_SELF_ENTRY] = dev_u1_self_entry_allow;
    cfg_word[ulc_pkg::BIT_HOST_ACCEPT] = host_u1_request_accept;
    cfg_word[ulc_pkg::BIT_LTM_ON] = latency_tolerance_msg_on;
    cfg_word[ulc_pkg::FS_TRIM_LO +: 3] = fullspeed_timeout_trim;
  end

  // status image: what the controller currently sees
  assign status_word = {27'h0, i_full_speed, o_ltm_active,
                        o_host_u1_accept, o_u1_self_entry_ok,
                        i_reset_protect};

  // read mux, zero for idle cycles and unmapped addresses
  always_comb begin
    next_rdata = 32'h0;
    if (rd_cfg) begin
      next_rdata = cfg_word;
    end else if (rd_status) begin
      next_rdata = status_word;
    end
  end

  // read data one cycle after the strobe, only there
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h0;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // base timeout, picked inside the 16 to 18 bit window
  assign base_tenths = 8'(FS_BASE_TENTHS);

  // each phy clock of trim adds 0.2 bit, only 60 mhz built
  assign trim_tenths = 8'(fullspeed_timeout_trim) * 8'(ulc_pkg::FS_TRIM_TENTHS_60MHZ);

  // controller-facing next values, one cycle behind the fields
  always_comb begin
    next_u1_self_entry_ok = dev_u1_self_entry_allow & i_host_u1_feature;
    next_host_u1_accept = host_u1_request_accept;
    next_ltm_active = latency_tolerance_msg_on;
    next_timeout_trim = i_full_speed ? fullspeed_timeout_trim : highspeed_timeout_trim;
    next_fs_timeout_tenths = base_tenths + trim_tenths;
  end

  // self entry permission to the controller
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_u1_self_entry_ok <= 1'h0;
    end else begin
      o_u1_self_entry_ok <= next_u1_self_entry_ok;
    end
  end

  // host request acceptance to the controller
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_host_u1_accept <= 1'h0;
    end else begin
      o_host_u1_accept <= next_host_u1_accept;
    end
  end

  // latency tolerance messaging state to the controller
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ltm_active <= 1'h0;
    end else begin
      o_ltm_active <= next_ltm_active;
    end
  end

  // trim presented for the current link speed
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_timeout_trim <= 3'h0;
    end else begin
      o_timeout_trim <= next_timeout_trim;
    end
  end

  // full-speed inter-packet timeout in tenths of a bit time
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fs_timeout_tenths <= 8'h0;
    end else begin
      o_fs_timeout_tenths <= next_fs_timeout_tenths;
    end
  end
endmodule // ulc_link_config

// *** verification/ulc_host_model.sv ***
// upstream port model: u1 feature and link speed levels
`timescale 1ns/10ps
module ulc_host_model (
  // clock
  input wire logic i_clk,
  // levels asked for by the bench
  input wire logic i_u1,
  input wire logic i_fs,
  // levels seen by the block
  output logic o_u1 = 1'b0,
  output logic o_fs = 1'b1
);
  // levels change only just after a clock edge
  always @(posedge i_clk) {o_u1, o_fs} <= {i_u1, i_fs};
endmodule // ulc_host_model

// *** verification/ulc_link_config_properties.sv ***
// port assertions for the link config block
`timescale 1ns/10ps
module ulc_link_config_props #(
  parameter int FS_BASE_TENTHS = 170
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // image presence, soft resets and protection
  input wire logic i_image_valid,
  input wire logic i_usb_reset,
  input wire logic i_lite_reset,
  input wire logic i_reset_protect,
  // link state
  input wire logic i_host_u1_feature,
  input wire logic i_full_speed,
  // controller-facing outputs
  input wire logic o_u1_self_entry_ok,
  input wire logic o_host_u1_accept,
  input wire logic o_ltm_active,
  input wire logic [2:0] o_timeout_trim,
  input wire logic [7:0] o_fs_timeout_tenths
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire sr = i_usb_reset || i_lite_reset;
  wire cfg = i_addr == ulc_pkg::ADDR_LINK_CONFIG_ONE;
  // config write, then a cycle free of soft reset
  sequence s_wr;
    i_wr && cfg && !sr ##1 !sr;
  endsequence
  AST_SELF: assert property (o_u1_self_entry_ok |-> $past(i_host_u1_feature))
    else $error("self entry without feature");
  AST_TENTHS: assert property ($past(!i_rst && i_full_speed) |->
    o_fs_timeout_tenths == FS_BASE_TENTHS + 2 * o_timeout_trim) else $error("fs timeout");
  AST_RSV: assert property ($past(i_rd && cfg) |-> !o_rdata[7] && o_rdata[3:0] == 0)
    else $error("reserved bits");
  AST_IDLE: assert property (!$past(i_rd) |-> o_rdata == 0) else $error("rdata idle");
  AST_HOST: assert property (s_wr |=> o_host_u1_accept == $past(i_wdata[9], 2))
    else $error("host accept");
  AST_LTM: assert property (s_wr |=> o_ltm_active == $past(i_wdata[8], 2))
    else $error("ltm");
  AST_PROT: assert property (sr && i_reset_protect && !(i_wr && cfg) |=> ##1
    $stable(o_host_u1_accept) && $stable(o_ltm_active)) else $error("protect");
  AST_DEF: assert property (sr && !i_reset_protect && !i_image_valid |-> ##2
    o_host_u1_accept && !o_ltm_active && o_fs_timeout_tenths == FS_BASE_TENTHS) else $error("def");
endmodule // ulc_link_config_props

// *** verification/ulc_link_config_tb.sv ***
// testbench for the link config block
`timescale 1ns/10ps
module ulc_link_config_tb;
  localparam logic [7:0] CFG = ulc_pkg::ADDR_LINK_CONFIG_ONE;
  logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_image_valid = 0, i_usb_reset = 0, u1 = 0;
  logic i_lite_reset = 0, i_reset_protect = 0, fs = 1, i_image_self_entry = 1;
  logic i_image_host_accept = 0, i_image_ltm_on = 1, i_host_u1_feature, i_full_speed;
  logic o_u1_self_entry_ok, o_host_u1_accept, o_ltm_active;
  logic [2:0] i_image_fs_trim = 3'h5, i_image_hs_trim = 3'h2, o_timeout_trim;
  logic [7:0] i_addr = 8'h00, o_fs_timeout_tenths;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  int errors = 0, compares = 0;
  always #50 i_clk = ~i_clk;
  ulc_link_config uut (.*);
  ulc_host_model host (.i_clk(i_clk), .i_u1(u1), .i_fs(fs), .o_u1(i_host_u1_feature),
    .o_fs(i_full_speed));
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic outs(input logic [13:0] exp);
    chk({o_u1_self_entry_ok, o_host_u1_accept, o_ltm_active, o_timeout_trim,
      o_fs_timeout_tenths}, exp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk) {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk) i_rd <= 0;
    @(negedge i_clk) chk(o_rdata, exp);
  endtask
  // write or soft reset, then wait for the outputs to follow
  task automatic wr(input logic [1:0] k, input logic [31:0] d);
    @(posedge i_clk) {i_wr, i_usb_reset, i_lite_reset, i_addr, i_wdata} <= {k == 0, k, CFG, d};
    @(posedge i_clk) {i_wr, i_usb_reset, i_lite_reset} <= 3'h0;
    repeat (2) @(negedge i_clk);
  endtask
  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 0;
    rd(CFG, 32'h200);
    outs(14'h10AA);
    rd(8'h80, 32'h0);
    @(posedge i_clk) u1 <= 1;
    wr(0, 32'hFFFFFFFF);
    rd(CFG, 32'hE770);
    outs(14'h3FB8);
    rd(ulc_pkg::ADDR_LINK_STATUS, 32'h1E);
    @(posedge i_clk) fs <= 0;
    wr(0, 32'h2430);
    outs(14'h21B0);
    @(posedge i_clk) {i_reset_protect, i_image_valid} <= 2'h3;
    wr(1, 32'h0);
    outs(14'h22B4);
    // host withdraws its u1 feature: self entry must drop
    @(posedge i_clk) u1 <= 0;
    repeat (3) @(negedge i_clk);
    outs(14'h02B4);
    // unprotected soft reset loads the image into bits 10:8
    @(posedge i_clk) i_reset_protect <= 0;
    wr(1, 32'h0);
    outs(14'h0AB4);
    rd(CFG, 32'h4550);
    @(posedge i_clk) {i_reset_protect, i_image_valid, fs} <= 3'h1;
    wr(2, 32'h0);
    outs(14'h10AA);
    report_and_stop;
  end
  // watchdog
  initial begin
    #200000;
    errors++;
    report_and_stop;
  end
endmodule // ulc_link_config_tb
bind ulc_link_config ulc_link_config_props #(.FS_BASE_TENTHS(FS_BASE_TENTHS)) chk (.*);
